//--- rtl/wdgdc_watchdog.sv
// Watchdog downcounter with chip reset pulse, AXI4-Lite register access
//
// Summary of operation
// - Hardware option: activation bit forced high from reset, writes cannot clear it.
// - Hardware option: reads of the activation bit may show 0 or 1.
// - Software option: inactive after reset, set once by software, clear ignored.
// - Seven-bit count (soft reset bit plus downcount bits) decrements every 3072 clocks.
// - Loaded count selects timeout in 64 steps of one decrement period.
// - Active and soft reset bit counted to zero: reset pin low about 500ns.
// - Writing zero to soft reset bit while active also causes a reset.
// - Never activated: counter runs as plain 7-bit timer, bits reversed in register.
// - In WAIT the watchdog counts and resets exactly as in run.
// - Watchdog inactive: stop instruction enters STOP mode.
// - Active, stop control off: stop instruction treated as wait.
// - Active, stop control on, interrupt pin low: stop treated as wait.
// - Active, stop control on, interrupt pin high: counter frozen, core stops.
// - Leaving STOP on an interrupt resumes counting from the frozen value.
// - Register: downcount bits 7..2 reversed, bit 7 LSB, soft reset bit 1, activation 0.
// - Register resets to FEh at address 0D8h, read and write.
// - Activation zero: soft reset bit is timer MSB, clearing it gives no reset.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module wdgdc_watchdog
   import wdgdc_pkg::*;
#(
   parameter int STEP_CYCLES = WDGDC_STEP_CYCLES,
   parameter int PULSE_CYCLES = WDGDC_RESET_PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Option straps and core interface
   input wire logic activationOption,
   input wire logic externalStopControlOption,
   input wire logic nmiPin,
   input wire logic stopRequest,
   input wire logic waitRequest,
   input wire logic wakeInterrupt,
   output logic resetPinN,
   output logic coreStop,
   output logic coreWait
);

   localparam int DIVW = $clog2(STEP_CYCLES);
   localparam int PULW = $clog2(PULSE_CYCLES + 1);
   localparam int PULSE_LAST = PULSE_CYCLES - 1; // Low edges after the first one

   // Elaboration check: a one-cycle divider or an empty pulse cannot be served
   if (STEP_CYCLES < 2 || PULSE_CYCLES < 1) begin : g_bad_params
      $error("wdgdc_watchdog: STEP_CYCLES must be >= 2, PULSE_CYCLES >= 1");
   end

   typedef struct packed {
      logic [1:0] nmiSync;
      logic optHw;
      logic optExt;
      logic [6:0] count;
      logic active;
      logic [DIVW-1:0] div;
      logic [PULW-1:0] pulse;
      wdgdc_pwr_t pwr;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } wdgdc_state_t;

   wdgdc_state_t state;
   wdgdc_state_t next_state;

   logic doWrite;
   logic [7:0] regView;
   logic stepTick;

   // Register view: downcount bits reversed in bits 7..2
   always_comb begin
      regView = 8'h00;
      for (int i = 0; i < 6; i++) begin
         regView[WDGDC_DOWN_LSB_BIT - i] = state.count[i];
      end
      regView[WDGDC_SOFT_RESET_BIT] = state.count[6];
      // Forced bit is shown as stored; a read may equally see the flop value
      regView[WDGDC_ACT_BIT] = state.active;
   end

   assign doWrite = state.awHeld && state.wHeld && !state.bValid;
   assign stepTick = (state.div == DIVW'(STEP_CYCLES - 1));

   // Next-state logic: bus, counter, reset pulse and power handling
   always_comb begin
      logic wrCount;
      logic [6:0] loadVal;
      logic frozen;
      wrCount = 1'b0;
      loadVal = 7'h00;
      frozen = 1'b0;
      next_state = state;
      next_state.nmiSync = {state.nmiSync[0], nmiPin};

      // Write address and data accepted in either order
      if (s_axi_awvalid && !state.awHeld) begin
         next_state.awHeld = 1'b1;
         next_state.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.wHeld) begin
         next_state.wHeld = 1'b1;
         next_state.wData = s_axi_wdata[7:0];
         next_state.wLane0 = s_axi_wstrb[0];
      end
      if (doWrite) begin
         next_state.awHeld = 1'b0;
         next_state.wHeld = 1'b0;
         next_state.bValid = 1'b1;
         if (state.awAddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2]) begin
            next_state.bResp = WDGDC_RESP_OKAY;
            wrCount = state.wLane0;
         end else if (state.awAddr[11:2] == WDGDC_CONFIG_REGISTER_ADDR[11:2]) begin
            next_state.bResp = WDGDC_RESP_OKAY; // Read-only, write ignored
         end else begin
            next_state.bResp = WDGDC_RESP_SLVERR;
         end
      end
      if (state.bValid && s_axi_bready) begin
         next_state.bValid = 1'b0;
      end

      // Read channel
      if (s_axi_arvalid && !state.rValid) begin
         next_state.rValid = 1'b1;
         next_state.rResp = WDGDC_RESP_OKAY;
         if (s_axi_araddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2]) begin
            next_state.rData = {24'h000000, regView};
         end else if (s_axi_araddr[11:2] == WDGDC_CONFIG_REGISTER_ADDR[11:2]) begin
            next_state.rData = {29'h00000000, coreStop, state.optExt, state.optHw};
         end else begin
            next_state.rData = 32'h00000000;
            next_state.rResp = WDGDC_RESP_SLVERR;
         end
      end else if (state.rValid && s_axi_rready) begin
         next_state.rValid = 1'b0;
      end

      // Power state: stop entry filtered by watchdog and stop-control option
      unique case (state.pwr)
         WDGDC_RUN: begin
            if (stopRequest) begin
               if (!state.active) begin
                  next_state.pwr = WDGDC_STOP;
               end else if (!state.optExt) begin
                  next_state.pwr = WDGDC_WAIT;
               end else if (!state.nmiSync[1]) begin
                  next_state.pwr = WDGDC_WAIT;
               end else begin
                  next_state.pwr = WDGDC_STOP;
               end
            end else if (waitRequest) begin
               next_state.pwr = WDGDC_WAIT;
            end
         end
         WDGDC_WAIT: begin
            if (wakeInterrupt) begin
               next_state.pwr = WDGDC_RUN;
            end
         end
         WDGDC_STOP: begin
            if (wakeInterrupt) begin
               next_state.pwr = WDGDC_RUN;
            end
         end
      endcase

      // Counter frozen whenever the core sits in STOP, as its clock is gone there
      frozen = (state.pwr == WDGDC_STOP);

      // Counter: write loads and restarts divider, else step every period
      if (wrCount) begin
         for (int i = 0; i < 6; i++) begin
            loadVal[i] = state.wData[WDGDC_DOWN_LSB_BIT - i];
         end
         loadVal[6] = state.wData[WDGDC_SOFT_RESET_BIT];
         next_state.count = loadVal;
         next_state.div = '0;
         if (state.wData[WDGDC_ACT_BIT]) begin
            next_state.active = 1'b1;
         end
         if (state.optHw) begin
            next_state.active = 1'b1;
         end
         // Soft reset written while active
         if ((state.active || state.wData[WDGDC_ACT_BIT]) && !loadVal[6]
               && state.pulse == '0) begin
            next_state.pulse = PULW'(PULSE_CYCLES);
         end
      end else if (!frozen) begin
         if (stepTick) begin
            next_state.div = '0;
            next_state.count = state.count - 7'h01;
            // Reset fires when soft reset bit falls through counting
            if (state.active && state.count[6] && !next_state.count[6]
                  && state.pulse == '0) begin
               next_state.pulse = PULW'(PULSE_CYCLES);
            end
         end else begin
            next_state.div = state.div + DIVW'(1);
         end
      end

      if (state.pulse != '0) begin
         next_state.pulse = state.pulse - PULW'(1);
      end
   end

   // State register; options caught at every edge while in reset
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state <= '0;
         state.count <= 7'h7f; // FEh view: all count bits and soft reset set
         state.optHw <= activationOption;
         state.optExt <= externalStopControlOption;
         state.active <= activationOption;
         state.pwr <= WDGDC_RUN;
         state.bResp <= WDGDC_RESP_OKAY;
         state.rResp <= WDGDC_RESP_OKAY;
      end else begin
         state <= next_state;
      end
   end

   // Outputs
   assign s_axi_awready = !state.awHeld;
   assign s_axi_wready = !state.wHeld;
   assign s_axi_bvalid = state.bValid;
   assign s_axi_bresp = state.bResp;
   assign s_axi_arready = !state.rValid;
   assign s_axi_rvalid = state.rValid;
   assign s_axi_rdata = state.rData;
   assign s_axi_rresp = state.rResp;
   assign resetPinN = (state.pulse == '0);
   assign coreStop = (state.pwr == WDGDC_STOP);
   assign coreWait = (state.pwr == WDGDC_WAIT);

   // Assertions: activation and counting
   a_hw_active_forced: assert property (@(posedge clock) disable iff (!resetn)
      state.optHw |-> state.active)
      else $error("activation lost under hardware option");
   a_sw_no_clear: assert property (@(posedge clock) disable iff (!resetn)
      $past(state.active) |-> state.active)
      else $error("watchdog deactivated after activation");
   a_div_step: assert property (@(posedge clock) disable iff (!resetn)
      (stepTick && !coreStop && !(doWrite && state.wLane0
      && state.awAddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2]))
      |=> state.count == $past(state.count) - 7'h01)
      else $error("counter did not step at divider end");
   a_count_hold: assert property (@(posedge clock) disable iff (!resetn)
      (!stepTick && !doWrite) |=> state.count == $past(state.count))
      else $error("counter moved between steps");
   a_wait_counts: assert property (@(posedge clock) disable iff (!resetn)
      (coreWait && stepTick && !doWrite) |=> state.count == $past(state.count) - 7'h01)
      else $error("counter stalled in wait");
   // Reset pulse: length, steadiness and both of its causes; then divider restart and register view
   a_pulse_len: assert property (@(posedge clock) disable iff (!resetn)
      $fell(resetPinN) |-> ##PULSE_LAST !resetPinN ##1 resetPinN)
      else $error("reset pulse length wrong");
   a_pulse_steady: assert property (@(posedge clock) disable iff (!resetn)
      (!resetPinN && state.pulse != PULW'(1)) |=> !resetPinN)
      else $error("reset pulse ended early");
   a_count_reset: assert property (@(posedge clock) disable iff (!resetn)
      (stepTick && !coreStop && !doWrite && state.active && state.count[6]
      && state.count[5:0] == '0 && resetPinN) |=> !resetPinN)
      else $error("no reset when soft reset bit counted out");
   a_soft_write_reset: assert property (@(posedge clock) disable iff (!resetn)
      (doWrite && state.wLane0 && state.active && !state.wData[WDGDC_SOFT_RESET_BIT]
      && state.awAddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2] && resetPinN)
      |=> !resetPinN)
      else $error("no reset on soft reset write");
   a_no_reset_idle: assert property (@(posedge clock) disable iff (!resetn)
      (!state.active && !doWrite && resetPinN) |=> resetPinN)
      else $error("reset while watchdog inactive");
   a_write_restart: assert property (@(posedge clock) disable iff (!resetn)
      (doWrite && state.awAddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2]
      && state.wLane0) |=> state.div == '0)
      else $error("divider not restarted on write");
   a_read_view: assert property (@(posedge clock) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[11:2] == WDGDC_WATCHDOG_COUNT_REGISTER_ADDR[11:2])
      |=> s_axi_rdata[WDGDC_SOFT_RESET_BIT] == $past(state.count[6])
      && s_axi_rdata[WDGDC_DOWN_LSB_BIT] == $past(state.count[0]))
      else $error("count register view misplaced");
   // Power filter and stop freeze
   a_stop_inactive: assert property (@(posedge clock) disable iff (!resetn)
      (state.pwr == WDGDC_RUN && stopRequest && !state.active) |=> coreStop)
      else $error("inactive watchdog blocked stop");
   a_stop_filter: assert property (@(posedge clock) disable iff (!resetn)
      (state.pwr == WDGDC_RUN && stopRequest && state.active && !state.optExt)
      |=> coreWait)
      else $error("stop not turned into wait");
   a_stop_nmi_low: assert property (@(posedge clock) disable iff (!resetn)
      (state.pwr == WDGDC_RUN && stopRequest && state.active && state.optExt
      && !state.nmiSync[1]) |=> coreWait)
      else $error("stop with interrupt pin low not turned into wait");
   a_stop_nmi_high: assert property (@(posedge clock) disable iff (!resetn)
      (state.pwr == WDGDC_RUN && stopRequest && state.active && state.optExt
      && state.nmiSync[1]) |=> coreStop)
      else $error("stop with interrupt pin high not entered");
   a_stop_freeze: assert property (@(posedge clock) disable iff (!resetn)
      (coreStop && !doWrite) |=> state.count == $past(state.count)
      && state.div == $past(state.div))
      else $error("counter ran in stop");
   a_wake_resume: assert property (@(posedge clock) disable iff (!resetn)
      (coreStop && wakeInterrupt) |=> !coreStop)
      else $error("stop not left on interrupt");

   c_timeout_reset: cover property (@(posedge clock) disable iff (!resetn) $fell(resetPinN));
   c_stop_entry: cover property (@(posedge clock) disable iff (!resetn) $rose(coreStop));
   c_wait_entry: cover property (@(posedge clock) disable iff (!resetn) $rose(coreWait));
   c_stop_resume: cover property (@(posedge clock) disable iff (!resetn) $fell(coreStop));
   c_nmi_wait: cover property (@(posedge clock) disable iff (!resetn) $rose(coreWait) && state.optExt);

endmodule : wdgdc_watchdog

//--- rtl/wdgdc_pkg.sv
// Package for the watchdog downcounter block: register map, fields, timing
package wdgdc_pkg;
   // Register map (printed offset is a multiple of four, so it is the byte address)
   localparam logic [11:0] WDGDC_WATCHDOG_COUNT_REGISTER_ADDR = 12'h0d8;
   localparam logic [11:0] WDGDC_CONFIG_REGISTER_ADDR = 12'h0dc;
   localparam logic [7:0] WDGDC_COUNT_RESET = 8'hfe;
   // Field positions of the count register
   localparam int WDGDC_ACT_BIT = 0;
   localparam int WDGDC_SOFT_RESET_BIT = 1;
   localparam int WDGDC_DOWN_LSB_BIT = 7;
   localparam int WDGDC_DOWN_MSB_BIT = 2;
   // Timing
   localparam int WDGDC_STEP_CYCLES = 3072;
   localparam int WDGDC_CLOCK_MHZ = 50;
   localparam int WDGDC_RESET_PULSE_NS = 500;
   localparam int WDGDC_RESET_PULSE_CYCLES_RAW = (WDGDC_RESET_PULSE_NS * WDGDC_CLOCK_MHZ) / 1000;
   localparam int WDGDC_RESET_PULSE_CYCLES =
      (WDGDC_RESET_PULSE_CYCLES_RAW < 1) ? 1 : WDGDC_RESET_PULSE_CYCLES_RAW;
   // AXI responses
   localparam logic [1:0] WDGDC_RESP_OKAY = 2'h0;
   localparam logic [1:0] WDGDC_RESP_SLVERR = 2'h2;
   // Watchdog power state
   typedef enum logic [2:0] {
      WDGDC_RUN = 3'h1,
      WDGDC_WAIT = 3'h2,
      WDGDC_STOP = 3'h4
   } wdgdc_pwr_t;
endpackage : wdgdc_pkg

//--- sim/tb_top.sv
// Self-checking bench for the watchdog downcounter block
`timescale 1ns/1ps
module tb_top;
   import wdgdc_pkg::*;
   // Short step keeps the run brief; the pulse keeps its real length
   localparam int STEP = 16;
   localparam int PULSE = 500 / 20;
   localparam logic [11:0] CNT = WDGDC_WATCHDOG_COUNT_REGISTER_ADDR;
   localparam logic [11:0] CFG = WDGDC_CONFIG_REGISTER_ADDR;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic activationOption = 1'b0;
   logic externalStopControlOption = 1'b0;
   logic nmiPin = 1'b0;
   logic stopRequest = 1'b0;
   logic waitRequest = 1'b0;
   logic wakeInterrupt = 1'b0;
   logic resetPinN;
   logic coreStop;
   logic coreWait;
   int mismatches = 0;
   int checks = 0;
   int lowRun = 0;
   int lastPulse = 0;
   int pulses = 0;
   int steps [4] = '{0, 1, 3, 4};

   wdgdc_watchdog #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE)) dut_u (
      .clock(clock), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .activationOption(activationOption),
      .externalStopControlOption(externalStopControlOption), .nmiPin(nmiPin),
      .stopRequest(stopRequest), .waitRequest(waitRequest),
      .wakeInterrupt(wakeInterrupt), .resetPinN(resetPinN),
      .coreStop(coreStop), .coreWait(coreWait));

   // 50 MHz clock
   initial begin
      forever #10 clock = ~clock;
   end

   // Pulse monitor: a pulse is counted once it ends, so its length is whole
   always @(posedge clock) begin
      if (resetPinN === 1'b0) begin
         lowRun++;
      end else if (lowRun != 0) begin
         lastPulse = lowRun;
         pulses++;
         lowRun = 0;
      end
   end

   // Register image: downcount mirrored into bits 7..2
   function automatic logic [7:0] enc(input logic [6:0] cnt, input logic act);
      logic [7:0] r;
      for (int k = 0; k < 6; k++) r[7 - k] = cnt[k];
      r[1] = cnt[6];
      r[0] = act;
      return r;
   endfunction : enc

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask : cycles

   // Straps are applied with reset so they are captured while it is held
   task automatic do_reset(input logic hw, input logic ext);
      @(posedge clock);
      activationOption <= hw;
      externalStopControlOption <= ext;
      nmiPin <= 1'b0;
      resetn <= 1'b0;
      cycles(3);
      resetn <= 1'b1;
   endtask : do_reset

   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid;
         resp = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         done = s_axi_rvalid;
         v = s_axi_rdata;
         resp = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
   endtask : rd

   // One-cycle stop, wait or wake pulse, then one edge for the state to land
   task automatic core_pulse(input logic stop, input logic wt = 1'b0);
      @(posedge clock);
      stopRequest <= stop;
      waitRequest <= wt;
      wakeInterrupt <= ~stop & ~wt;
      @(posedge clock);
      stopRequest <= 1'b0;
      waitRequest <= 1'b0;
      wakeInterrupt <= 1'b0;
      @(posedge clock);
   endtask : core_pulse

   task automatic expect_pulse(input int limit);
      int p0;
      p0 = pulses;
      repeat (limit + PULSE + 2) begin
         @(posedge clock);
         if (pulses != p0) break;
      end
      check_word(32'(pulses - p0), 32'h1);
      check_word(32'(lastPulse), 32'(PULSE));
   endtask : expect_pulse

   // Run limit: the tests need under 2000 cycles, so 5000 means a hang
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int p0;
      do_reset(1'b0, 1'b0);
      rd(CNT, d, r);
      check_word(d, 32'(WDGDC_COUNT_RESET));
      rd(CFG, d, r);
      check_word(d, 32'h0);
      rd(12'h0e0, d, r);
      check_word({d[29:0], r}, {30'h0, WDGDC_RESP_SLVERR});
      wr(12'h0e0, 32'hff, r);
      check_word(32'(r), 32'(WDGDC_RESP_SLVERR));
      // Timer use; clearing the top bit while inactive gives no pulse
      foreach (steps[i]) begin
         wr(CNT, 32'(enc(7'h03, 1'b0)), r);
         cycles(6 + steps[i] * STEP);
         rd(CNT, d, r);
         check_word(d, 32'(enc(7'h03 - 7'(steps[i]), 1'b0)));
         // Second read lands inside the same step, so both must agree
         rd(CNT, d, r);
         check_word(d, 32'(enc(7'h03 - 7'(steps[i]), 1'b0)));
      end
      check_word(32'(pulses), 32'h0);
      core_pulse(1'b1);
      check_word(32'({coreStop, coreWait}), 32'h2);
      core_pulse(1'b0);
      check_word(32'({coreStop, coreWait}), 32'h0);
      core_pulse(1'b0, 1'b1);
      check_word(32'({coreStop, coreWait}), 32'h1);
      core_pulse(1'b0);
      check_word(32'({coreStop, coreWait}), 32'h0);
      // Software activation sticks, then counting out gives a pulse
      wr(CNT, 32'(enc(7'h41, 1'b1)), r);
      rd(CNT, d, r);
      check_word(d, 32'(enc(7'h41, 1'b1)));
      wr(CNT, 32'(enc(7'h41, 1'b0)), r);
      rd(CNT, d, r);
      check_word(32'(d[0]), 32'h1);
      expect_pulse(3 * STEP);
      do_reset(1'b0, 1'b0);
      wr(CNT, 32'(enc(7'h7f, 1'b1)), r);
      wr(CNT, 32'(enc(7'h3f, 1'b1)), r);
      expect_pulse(4);
      // Hardware option: reload faster than two steps, then stop reloading
      do_reset(1'b1, 1'b0);
      rd(CNT, d, r);
      check_word(d & 32'hfe, 32'(WDGDC_COUNT_RESET) & 32'hfe);
      rd(CFG, d, r);
      check_word(d, 32'h1);
      p0 = pulses;
      repeat (6) begin
         wr(CNT, 32'(enc(7'h41, 1'b0)), r);
         cycles(STEP + 8);
      end
      check_word(32'(pulses - p0), 32'h0);
      expect_pulse(3 * STEP);
      do_reset(1'b1, 1'b0);
      wr(CNT, 32'(enc(7'h41, 1'b1)), r);
      core_pulse(1'b1);
      check_word(32'({coreStop, coreWait}), 32'h1);
      expect_pulse(3 * STEP);
      // Stop control by the interrupt pin
      do_reset(1'b1, 1'b1);
      rd(CFG, d, r);
      check_word(d, 32'h3);
      wr(CNT, 32'(enc(7'h7f, 1'b1)), r);
      core_pulse(1'b1);
      check_word(32'({coreStop, coreWait}), 32'h1);
      core_pulse(1'b0);
      check_word(32'({coreStop, coreWait}), 32'h0);
      nmiPin <= 1'b1;
      wr(CNT, 32'(enc(7'h41, 1'b1)), r);
      core_pulse(1'b1);
      check_word(32'({coreStop, coreWait}), 32'h2);
      p0 = pulses;
      cycles(4 * STEP);
      rd(CNT, d, r);
      check_word(d, 32'(enc(7'h41, 1'b1)));
      rd(CFG, d, r);
      check_word(32'(d[2]), 32'h1);
      check_word(32'(pulses - p0), 32'h0);
      core_pulse(1'b0);
      expect_pulse(3 * STEP);
      tally_and_finish();
   end
endmodule : tb_top
